// ### verilog/dcti_top.sv
`timescale 1ns/100ps
`default_nettype none

module dcti_top
  import dcti_pkg::*;
#(
  parameter int unsigned FILTER_CYCLES = PULSE_REJECT_CYC,
  parameter int unsigned DISC_CYCLES = DISC_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic inhibit_channel_a_in_i,
  input wire logic inhibit_channel_b_in_i,
  output logic run_permit_o,
  output logic torque_inhibit_o,
  output logic inhibit_status_on_o,
  output logic fault_locked_o
);

  localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILTER_CYCLES - 1);
  localparam logic [DISC_W-1:0] DISC_LAST = DISC_W'(DISC_CYCLES);

  // channel input pair
  logic [1:0] raw;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] filt_q;
  logic [DISC_W-1:0] disc_q;
  logic disc_hit_q;
  logic fault_q;
  logic torque_q;
  dcti_state_t state_q;
  dcti_state_t state_d;
  dcti_out_t out_d;
  dcti_out_t out_q;

  // channels at opposite levels
  function automatic logic chan_disagree(input logic [1:0] lv);
    chan_disagree = lv[0] ^ lv[1];
  endfunction

  // both channels at the given level
  function automatic logic both_level(input logic [1:0] lv, input logic v);
    both_level = (lv[0] == v) && (lv[1] == v);
  endfunction

  // outputs for each state
  function automatic dcti_out_t state_outputs(input dcti_state_t st);
    dcti_out_t o;
    o = '0;
    case (st)
      DCTI_RUN: begin
        o.run_permit = 1'b1;
      end
      DCTI_SAFE: begin
        o.status_on = 1'b1;
      end
      DCTI_DISAGREE: begin
        o.status_on = 1'b0;
      end
      DCTI_LOCKED: begin
        o.fault = 1'b1;
      end
      default: begin
        o = '0;
      end
    endcase
    return o;
  endfunction

  assign raw = {inhibit_channel_b_in_i, inhibit_channel_a_in_i};

  // two-stage synchroniser per channel
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= raw[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate

  // low-going glitch filter per channel
  generate
    for (g = 0; g < 2; g++) begin : g_filt
      logic [FILT_W-1:0] low_cnt_q;
      logic low_done;

      // low run long enough to count
      assign low_done = (low_cnt_q >= FILT_LAST);

      // length of the current low run
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          low_cnt_q <= '0;
        end else if (sync2_q[g]) begin
          low_cnt_q <= '0;
        end else if (!low_done) begin
          low_cnt_q <= low_cnt_q + FILT_W'(1);
        end
      end

      // filtered level, rises pass at once
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          filt_q[g] <= 1'b0;
        end else if (sync2_q[g]) begin
          filt_q[g] <= 1'b1;
        end else if (low_done) begin
          filt_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // discrepancy timer
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      disc_q <= '0;
    end else if (!chan_disagree(filt_q)) begin
      disc_q <= '0;
    end else if (disc_q < DISC_LAST) begin
      disc_q <= disc_q + DISC_W'(1);
    end
  end

  // registered threshold compare
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      disc_hit_q <= 1'b0;
    end else begin
      disc_hit_q <= (disc_q >= DISC_LAST);
    end
  end

  // fault latch, cleared only by the synchronous reset srst_i
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fault_q <= 1'b0;
    end else if (disc_hit_q) begin
      fault_q <= 1'b1;
    end
  end

  // state from filtered levels
  always_comb begin
    state_d = DCTI_SAFE;
    if (fault_q) begin
      state_d = DCTI_LOCKED;
    end else if (both_level(filt_q, 1'b1)) begin
      state_d = DCTI_RUN;
    end else if (both_level(filt_q, 1'b0)) begin
      state_d = DCTI_SAFE;
    end else begin
      state_d = DCTI_DISAGREE;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= DCTI_SAFE;
    end else begin
      state_q <= state_d;
    end
  end

  // decoded outputs
  always_comb begin
    out_d = state_outputs(state_q);
  end

  // registered outputs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  // inhibit pin has a flop of its own
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      torque_q <= 1'b1;
    end else begin
      torque_q <= ~out_d.run_permit;
    end
  end

  // pins
  assign run_permit_o = out_q.run_permit;
  assign torque_inhibit_o = torque_q;
  assign inhibit_status_on_o = out_q.status_on;
  assign fault_locked_o = out_q.fault;

endmodule

`default_nettype wire

// ### shared/dcti_pkg.sv
package dcti_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;
  // glitch filter: low pulses narrower than this are ignored
  localparam int unsigned PULSE_REJECT_US = 2000;
  localparam int unsigned PULSE_REJECT_CYC = (CLK_HZ / 1_000_000) * PULSE_REJECT_US;
  // discrepancy threshold, nominal detection time
  localparam int unsigned DISC_NOM_MS = 2300;
  localparam int unsigned DISC_MIN_MS = 1600;
  localparam int unsigned DISC_MAX_MS = 3000;
  localparam int unsigned DISC_CYC = (CLK_HZ / 1000) * DISC_NOM_MS;
  localparam int unsigned FILT_W = 17;
  localparam int unsigned DISC_W = 27;

  typedef enum logic [1:0] {
    DCTI_SAFE,
    DCTI_RUN,
    DCTI_DISAGREE,
    DCTI_LOCKED
  } dcti_state_t;

  typedef struct packed {
    logic run_permit;
    logic status_on;
    logic fault;
  } dcti_out_t;

endpackage

// ### bench/dcti_sva.sv
`timescale 1ns/100ps
`default_nettype none
module dcti_sva #(
  parameter int unsigned FILTER_CYCLES = 4,
  parameter int unsigned DISC_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic inhibit_channel_a_in_i,
  input wire logic inhibit_channel_b_in_i,
  input wire logic run_permit_o,
  input wire logic torque_inhibit_o,
  input wire logic inhibit_status_on_o,
  input wire logic fault_locked_o
);
  wire a = inhibit_channel_a_in_i;
  wire b = inhibit_channel_b_in_i;
  wire r = run_permit_o;
  wire f = fault_locked_o;
  int dq;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // raw disagreement length
  always_ff @(posedge clk_i) dq <= (srst_i || a == b) ? 0 : dq + 1;
  sequence s_hi; (a && b && !f) [*8] ##1 !f; endsequence
  sequence s_lo; (!a && !b && !f) [*8]; endsequence
  property p_inv; torque_inhibit_o != r; endproperty
  property p_a; !a [*8] |-> ##4 !r; endproperty
  property p_b; !b [*8] |-> ##4 !r; endproperty
  property p_run; s_hi |-> r; endproperty
  property p_safe; s_lo |-> ##4 (inhibit_status_on_o || f); endproperty
  property p_hold; f |=> f; endproperty
  property p_lock; f |-> !r && !inhibit_status_on_o; endproperty
  property p_disc; dq == DISC_CYCLES + 16 |-> f; endproperty
  a_inv: assert property (p_inv) else $error("inv");
  a_a: assert property (p_a) else $error("a low");
  a_b: assert property (p_b) else $error("b low");
  a_run: assert property (p_run) else $error("run");
  a_safe: assert property (p_safe) else $error("safe");
  a_hold: assert property (p_hold) else $error("hold");
  a_lock: assert property (p_lock) else $error("lock");
  a_disc: assert property (p_disc) else $error("disc");
endmodule
bind dcti_top dcti_sva #(.FILTER_CYCLES(FILTER_CYCLES), .DISC_CYCLES(DISC_CYCLES)) dcti_sva_inst (.*);
`default_nettype wire

// ### bench/dcti_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module dcti_ctrl_model (
  input wire logic clk_i,
  input wire logic req_a_i,
  input wire logic req_b_i,
  input wire logic ossd_i,
  output var logic chan_a_o = 1'b0,
  output var logic chan_b_o = 1'b0
);
  logic [3:0] ph_q = 4'h0;
  // three-cycle low test pulses
  always_ff @(posedge clk_i) ph_q <= ph_q + 4'h1;
  always_ff @(posedge clk_i) chan_a_o <= req_a_i && !(ossd_i && ph_q < 4'h3);
  always_ff @(posedge clk_i) chan_b_o <= req_b_i && !(ossd_i && ph_q[3] && ph_q < 4'hB);
endmodule
`default_nettype wire

// ### bench/dual_channel_torque_inhibit_bench.sv
`timescale 1ns/100ps
`default_nettype none
module dual_channel_torque_inhibit_bench;
  logic clk_i = 1'b0, srst_i = 1'b1, ra = 1'b0, rb = 1'b0, os = 1'b0;
  logic inhibit_channel_a_in_i, inhibit_channel_b_in_i;
  logic run_permit_o, torque_inhibit_o, inhibit_status_on_o, fault_locked_o;
  int errors = 0, checked = 0, cyc = 0;
  always #12.5 clk_i = ~clk_i;
  dcti_ctrl_model dcti_ctrl_model_inst (.clk_i(clk_i), .req_a_i(ra), .req_b_i(rb), .ossd_i(os),
    .chan_a_o(inhibit_channel_a_in_i), .chan_b_o(inhibit_channel_b_in_i));
  dcti_top #(.FILTER_CYCLES(4), .DISC_CYCLES(20)) dcti_top_inst (.*);
  task final_report;
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_i) if (++cyc == 2000) begin
    errors++;
    final_report();
  end
  task chk(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s exp %b got %b", n, e, g);
    end
  endtask
  task go(input logic na, input logic nb, input logic no, input int n);
    @(posedge clk_i);
    ra <= na;
    rb <= nb;
    os <= no;
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task t_run;
    go(1, 1, 1, 40);
    chk("run", 1, run_permit_o);
    chk("torque", 0, torque_inhibit_o);
    chk("status", 0, inhibit_status_on_o);
  endtask
  task t_one_low;
    go(1, 0, 0, 12);
    chk("run", 0, run_permit_o);
    go(1, 1, 0, 10);
    go(0, 1, 0, 12);
    chk("torque", 1, torque_inhibit_o);
    chk("status", 0, inhibit_status_on_o);
    go(0, 0, 0, 20);
    chk("status", 1, inhibit_status_on_o);
    chk("fault", 0, fault_locked_o);
  endtask
  task t_fault;
    go(1, 0, 0, 50);
    chk("fault", 1, fault_locked_o);
    go(1, 1, 0, 20);
    chk("run", 0, run_permit_o);
    go(0, 0, 0, 20);
    chk("status", 0, inhibit_status_on_o);
    @(posedge clk_i);
    srst_i <= 1'b1;
    go(0, 0, 0, 3);
    @(posedge clk_i);
    srst_i <= 1'b0;
    go(0, 0, 0, 10);
    chk("fault", 0, fault_locked_o);
    chk("status", 1, inhibit_status_on_o);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    t_run();
    t_one_low();
    t_fault();
    final_report();
  end
endmodule
`default_nettype wire
